// [common/wsm_pkg.sv]
package wsm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int MS_NS = 1000000;
    // Milliseconds tick divider, rounded down (never a longer period)
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    // Least fault duration treated as real, rounded up to whole cycles
    localparam int GLITCH_NS = 1000;
    localparam int GLITCH_CYCLES = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Recovery hold time; one extra tick so a partial first ms never counts
    localparam int PSM_RECOVER_MS = 256;
    localparam int PSM_RECOVER_TICKS = PSM_RECOVER_MS + 1;
    localparam logic [11:0] WD_BASE_MS = 12'h010;

    ////////////////////////////////////////////////////////////////////////
    // Special-function register addresses
    localparam logic [7:0] WD_CTRL_ADDR = 8'hc0;
    localparam logic [7:0] PSM_CTRL_ADDR = 8'hdf;
    localparam logic [7:0] IE2_ADDR = 8'ha9;

    // watchdog_control fields
    localparam int WD_SEL_LSB = 5;
    localparam int WD_REF1_BIT = 3;
    localparam int WD_REF2_BIT = 2;
    localparam int WD_FLAG_BIT = 1;
    localparam int WD_EN_BIT = 0;

    // supply_monitor_control fields
    localparam int PSM_STAT_BIT = 6;
    localparam int PSM_IRQ_BIT = 5;
    localparam int PSM_TRIP_LSB = 2;
    localparam int PSM_SRC_BIT = 1;
    localparam int PSM_ON_BIT = 0;

    // Second interrupt enable fields
    localparam int IE2_PSM_BIT = 1;

    // Reset values
    localparam logic [2:0] WD_SEL_RST = 3'h0;
    localparam logic WD_EN_RST = 1'b0;
    localparam logic PSM_ON_RST = 1'b0;
    localparam logic [2:0] TRIP_RST = 3'h0;
    localparam logic [1:0] IE2_RST = 2'h0;

    // Refresh sequence tracking
    typedef enum logic {
        WSM_REF_IDLE,
        WSM_REF_ARMED
    } wsm_ref_e;

    // Timeout in ms for a prescale code: 16 ms doubled per code step
    function automatic logic [11:0] wsm_timeout_ms(input logic [2:0] sel);
        wsm_timeout_ms = WD_BASE_MS << sel;
    endfunction : wsm_timeout_ms

endpackage : wsm_pkg

// [core/wsm_monitor.sv]
`timescale 1ns/1ps
module wsm_monitor #(
    parameter int unsigned MS_CYCLES = wsm_pkg::MS_CYCLES,
    parameter int unsigned GLITCH_CYCLES = wsm_pkg::GLITCH_CYCLES
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic analog_supply_low,
    input wire logic digital_supply_low,
    output logic psm_enable,
    output logic [2:0] trip_sel,
    output logic wd_system_reset,
    output logic supply_fault_irq
);
    localparam logic [7:0] GL = 8'(GLITCH_CYCLES);
    localparam logic [8:0] REC = 9'(wsm_pkg::PSM_RECOVER_TICKS);

    typedef struct packed {
        logic [2:0] wd_sel;
        logic wd_en;
        logic wd_flag;
        wsm_pkg::wsm_ref_e ref_st;
        logic [11:0] wd_ms;
        logic wd_rst;
        logic psm_on;
        logic [2:0] trip;
        logic psm_irq;
        logic psm_src;
        logic [1:0] sync_a;
        logic [1:0] sync_d;
        logic [7:0] glitch;
        logic [8:0] rec_ms;
        logic [1:0] ie2;
        logic [7:0] rdata;
    } wsm_state_s;

    wsm_state_s q;
    wsm_state_s n;
    logic tick;
    logic below;
    logic fault;
    logic wr_wd;
    logic [11:0] limit;

    wsm_tick_gen #(
        .CYCLES(MS_CYCLES)
    ) u_tick (
        .mclk(mclk),
        .srst(srst),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decodes shared by logic and checks
    assign below = q.sync_a[1] | q.sync_d[1];
    assign fault = (q.glitch == GL);
    assign wr_wd = sfr_wr && (sfr_addr == wsm_pkg::WD_CTRL_ADDR);
    assign limit = wsm_pkg::wsm_timeout_ms(q.wd_sel);

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb
    begin
        n = q;
        n.wd_rst = 1'b0;
        // Comparator pins are asynchronous to mclk
        n.sync_a = {q.sync_a[0], analog_supply_low};
        n.sync_d = {q.sync_d[0], digital_supply_low};

        // Register writes
        if (wr_wd)
        begin
            n.wd_sel = sfr_wdata[wsm_pkg::WD_SEL_LSB +: 3];
            n.wd_en = sfr_wdata[wsm_pkg::WD_EN_BIT];
            // Flag clears on a written 0; a timeout below overrides it
            if (!sfr_wdata[wsm_pkg::WD_FLAG_BIT])
            begin
                n.wd_flag = 1'b0;
            end
            if (q.ref_st == wsm_pkg::WSM_REF_ARMED && sfr_wdata[wsm_pkg::WD_REF2_BIT])
            begin
                n.wd_ms = '0;
                n.ref_st = wsm_pkg::WSM_REF_IDLE;
            end
            else if (sfr_wdata[wsm_pkg::WD_REF1_BIT] && !sfr_wdata[wsm_pkg::WD_REF2_BIT])
            begin
                n.ref_st = wsm_pkg::WSM_REF_ARMED;
            end
            else
            begin
                n.ref_st = wsm_pkg::WSM_REF_IDLE;
            end
        end
        if (sfr_wr && sfr_addr == wsm_pkg::PSM_CTRL_ADDR)
        begin
            n.psm_on = sfr_wdata[wsm_pkg::PSM_ON_BIT];
            // trip code goes straight to the comparator
            n.trip = sfr_wdata[wsm_pkg::PSM_TRIP_LSB +: 3];
        end
        if (sfr_wr && sfr_addr == wsm_pkg::IE2_ADDR)
        begin
            n.ie2 = sfr_wdata[1:0];
        end

        // disabled watchdog holds its count at zero
        if (!n.wd_en)
        begin
            n.wd_ms = '0;
            n.ref_st = wsm_pkg::WSM_REF_IDLE;
        end
        else if (tick && !(wr_wd && q.ref_st == wsm_pkg::WSM_REF_ARMED
                           && sfr_wdata[wsm_pkg::WD_REF2_BIT]))
        begin
            if (q.wd_ms == limit - 12'h001)
            begin
                n.wd_rst = 1'b1;
                n.wd_ms = '0;
                // timeout flag set wins over a clear
                n.wd_flag = 1'b1;
            end
            else
            begin
                n.wd_ms = q.wd_ms + 12'h001;
            end
        end

        // powered-down monitor drops filter count, recovery count and flag; source bit is kept
        if (!q.psm_on)
        begin
            n.glitch = '0;
            n.rec_ms = '0;
            n.psm_irq = 1'b0;
        end
        // fault must persist GLITCH_CYCLES before it counts
        else if (below)
        begin
            n.rec_ms = '0;
            if (q.glitch != GL)
            begin
                n.glitch = q.glitch + 8'h01;
            end
            // raise and note which supply dipped
            if (q.glitch == GL - 8'h01)
            begin
                n.psm_irq = 1'b1;
                n.psm_src = q.sync_a[1];
            end
        end
        else
        begin
            n.glitch = '0;
            // hold until continuously good for the recovery time
            if (q.psm_irq && tick)
            begin
                if (q.rec_ms == REC - 9'h001)
                begin
                    n.psm_irq = 1'b0;
                    n.rec_ms = '0;
                end
                else
                begin
                    n.rec_ms = q.rec_ms + 9'h001;
                end
            end
        end

        // Read data registered; unmapped addresses read zero
        if (sfr_rd)
        begin
            unique case (sfr_addr)
                // flag sits beside enable, refresh bits read 0
                wsm_pkg::WD_CTRL_ADDR: n.rdata = {q.wd_sel, 3'h0, q.wd_flag, q.wd_en};
                wsm_pkg::PSM_CTRL_ADDR: n.rdata = {1'b0, !fault, q.psm_irq, q.trip,
                                                 q.psm_src, q.psm_on};
                wsm_pkg::IE2_ADDR: n.rdata = {6'h00, q.ie2};
                default: n.rdata = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            q <= '0;
            q.wd_sel <= wsm_pkg::WD_SEL_RST;
            q.wd_en <= wsm_pkg::WD_EN_RST;
            q.psm_on <= wsm_pkg::PSM_ON_RST;
            q.trip <= wsm_pkg::TRIP_RST;
            q.ie2 <= wsm_pkg::IE2_RST;
        end
        else
        begin
            q <= n;
        end
    end

    assign sfr_rdata = q.rdata;
    assign psm_enable = q.psm_on;
    assign trip_sel = q.trip;
    assign wd_system_reset = q.wd_rst;
    // core sees the flag only when enabled
    assign supply_fault_irq = q.psm_irq & q.ie2[wsm_pkg::IE2_PSM_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    sequence s_ref_one;
        wr_wd && sfr_wdata[wsm_pkg::WD_REF1_BIT] && !sfr_wdata[wsm_pkg::WD_REF2_BIT]
            && sfr_wdata[wsm_pkg::WD_EN_BIT];
    endsequence
    sequence s_ref_two;
        wr_wd && sfr_wdata[wsm_pkg::WD_REF2_BIT] && sfr_wdata[wsm_pkg::WD_EN_BIT];
    endsequence
    // Strobes are two cycles apart at best, so allow one quiet cycle between steps
    sequence s_ref_gap;
        !wr_wd;
    endsequence

    a_wd_off_quiet: assert property (!q.wd_en && !wr_wd |=> !q.wd_rst)
        else $error("watchdog reset while disabled");
    a_wd_timeout_hit: assert property (tick && q.wd_en && !wr_wd
        && q.wd_ms == limit - 12'h001 |=> q.wd_rst && q.wd_ms == 12'h000)
        else $error("watchdog missed its timeout");
    a_wd_no_early: assert property (q.wd_rst |-> $past(q.wd_ms) == $past(limit) - 12'h001)
        else $error("watchdog reset at wrong count");
    a_wd_flag_set: assert property (q.wd_rst |-> q.wd_flag)
        else $error("timeout flag not set");
    a_wd_pair_ok: assert property (s_ref_one ##1 s_ref_gap ##1 s_ref_two
        |=> q.wd_ms == 12'h000)
        else $error("ordered refresh did not restart");
    a_psm_filter: assert property (!q.psm_irq && q.glitch < GL - 8'h01 |=> !q.psm_irq)
        else $error("glitch raised supply interrupt");
    a_psm_raise: assert property (q.psm_on && below && q.glitch == GL - 8'h01
        |=> q.psm_irq && q.psm_src == $past(q.sync_a[1]))
        else $error("supply fault not raised");
    a_psm_hold: assert property (q.psm_on && q.psm_irq && (below || !tick
        || q.rec_ms != REC - 9'h001) |=> q.psm_irq)
        else $error("supply interrupt dropped early");
    a_psm_off: assert property (!q.psm_on |=> !q.psm_irq)
        else $error("monitor off but interrupt set");
    a_psm_status: assert property (sfr_rd && sfr_addr == wsm_pkg::PSM_CTRL_ADDR
        |=> sfr_rdata[6] == $past(!fault) && sfr_rdata[5] == $past(q.psm_irq))
        else $error("status bits read wrong");

endmodule : wsm_monitor

// [core/wsm_tick_gen.sv]
`timescale 1ns/1ps
// One-cycle enable pulse every CYCLES clocks
module wsm_tick_gen #(
    parameter int unsigned CYCLES = wsm_pkg::MS_CYCLES
) (
    input wire logic mclk,
    input wire logic srst,
    output logic tick
);
    localparam int CW = $clog2(CYCLES);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } wsm_tick_s;

    wsm_tick_s q;
    wsm_tick_s n;

    ////////////////////////////////////////////////////////////////////////
    // Free-running divider, pulse registered for a clean enable
    always_comb
    begin
        n = q;
        n.tick = 1'b0;
        if (q.cnt == LAST)
        begin
            n.cnt = '0;
            n.tick = 1'b1;
        end
        else
        begin
            n.cnt = q.cnt + 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            q <= '0;
        end
        else
        begin
            q <= n;
        end
    end

    assign tick = q.tick;

endmodule : wsm_tick_gen

// [verif/wsm_tb.sv]
`timescale 1ns/1ps
module testbench;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic analog_supply_low = 1'b0;
    logic digital_supply_low = 1'b0;
    logic psm_enable;
    logic [2:0] trip_sel;
    logic wd_system_reset;
    logic supply_fault_irq;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    int pulses = 0;
    int p0;
    int n;
    localparam logic [7:0] WD = wsm_pkg::WD_CTRL_ADDR;
    localparam logic [7:0] PS = wsm_pkg::PSM_CTRL_ADDR;
    localparam logic [7:0] IE = wsm_pkg::IE2_ADDR;

    ////////////////////////////////////////////////////////////////////////
    // Short ms tick and glitch filter keep the 2048 ms case affordable
    wsm_monitor #(.MS_CYCLES(10), .GLITCH_CYCLES(4)) wsm_monitor_inst (
        .mclk(mclk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .analog_supply_low(analog_supply_low),
        .digital_supply_low(digital_supply_low), .psm_enable(psm_enable),
        .trip_sel(trip_sel), .wd_system_reset(wd_system_reset),
        .supply_fault_irq(supply_fault_irq));

    // Free running clock
    initial
    begin
        forever #10 mclk = ~mclk;
    end

    // Pulse counter and hang guard
    always @(posedge mclk)
    begin
        cyc++;
        if (wd_system_reset === 1'b1)
            pulses++;
        if (cyc == 70000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic idle(input int k);
        repeat (k) @(negedge mclk);
    endtask : idle

    // One-cycle strobes; the gap cycle avoids double assignment per step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge mclk);
        sfr_wr = 1'b0;
    endtask : wr

    // Data is registered at the read edge, so it is settled one half cycle later
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(negedge mclk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge mclk);
        sfr_rd = 1'b0;
        check(what, sfr_rdata, exp);
    endtask : rd

    task automatic refresh(input logic [2:0] s);
        wr(WD, {s, 5'b01001});
        wr(WD, {s, 5'b00101});
    endtask : refresh

    task automatic wait_wd(input int lim, output int k);
        k = 0;
        while (wd_system_reset !== 1'b1 && k < lim)
        begin
            @(negedge mclk);
            k++;
        end
    endtask : wait_wd

    task automatic tally_and_finish();
        if (error_cnt == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        idle(10);
        srst = 1'b0;
        rd(WD, 8'h00, "wd ctrl reset");
        rd(PS, 8'h40, "psm ctrl reset");
        rd(IE, 8'h00, "ie2 reset");
        wr(8'h80, 8'h55);
        rd(8'h80, 8'h00, "unmapped");
        wr(IE, 8'hff);
        rd(IE, 8'h03, "ie2 bits");
        // Every prescale code, timed from an ordered refresh; tick phase gives slack
        for (int s = 0; s < 8; s++)
        begin
            refresh(3'(s));
            wait_wd(20600, n);
            check("wd timeout", {7'h00, n >= (160 << s) - 12 && n <= (160 << s) + 3}, 8'h01);
            idle(1);
            check("wd pulse", {7'h00, wd_system_reset}, 8'h00);
            rd(WD, {3'(s), 5'b00011}, "wd flag");
        end
        // A lone step two must not restart the count
        refresh(3'h0);
        idle(80);
        wr(WD, 8'h05);
        wait_wd(200, n);
        check("stray step two", {7'h00, n <= 84}, 8'h01);
        // Let the pulse counter take this pulse before the baseline is taken
        idle(1);
        // Ordered refreshes keep it quiet, then disabling silences it
        p0 = pulses;
        repeat (4)
        begin
            idle(100);
            refresh(3'h0);
        end
        wr(WD, 8'h00);
        idle(400);
        check("no reset", 8'(pulses - p0), 8'h00);
        rd(WD, 8'h00, "wd off");
        // Trip codes 0 to 4 reach the comparators
        for (int t = 0; t < 5; t++)
        begin
            wr(PS, 8'((t << 2) | 1));
            check("trip out", {5'h00, trip_sel}, 8'(t));
            rd(PS, 8'(8'h41 | (t << 2)), "trip field");
        end
        check("psm on", {7'h00, psm_enable}, 8'h01);
        wr(PS, 8'h09);
        analog_supply_low = 1'b1;
        idle(2);
        analog_supply_low = 1'b0;
        idle(20);
        check("glitch irq", {7'h00, supply_fault_irq}, 8'h00);
        rd(PS, 8'h49, "after glitch");
        analog_supply_low = 1'b1;
        idle(12);
        check("analog irq", {7'h00, supply_fault_irq}, 8'h01);
        rd(PS, 8'h2b, "analog fault");
        analog_supply_low = 1'b0;
        idle(10);
        rd(PS, 8'h6b, "held flag");
        idle(2400);
        check("hold irq", {7'h00, supply_fault_irq}, 8'h01);
        idle(300);
        check("recovered", {7'h00, supply_fault_irq}, 8'h00);
        digital_supply_low = 1'b1;
        idle(12);
        digital_supply_low = 1'b0;
        idle(6);
        rd(PS, 8'h69, "digital fault");
        // Masking only gates the output, the flag stays
        wr(IE, 8'h00);
        idle(1);
        check("masked", {7'h00, supply_fault_irq}, 8'h00);
        wr(IE, 8'h02);
        idle(1);
        check("unmasked", {7'h00, supply_fault_irq}, 8'h01);
        wr(PS, 8'h08);
        rd(PS, 8'h48, "monitor off");
        check("psm off", {7'h00, psm_enable}, 8'h00);
        check("off irq", {7'h00, supply_fault_irq}, 8'h00);
        tally_and_finish();
    end
endmodule : testbench
